// ### rtc_regs_pkg.sv
// Constants for the special-purpose register set of the serial clock:
// offsets, field positions, reset values and pointer wrap points.
// Assumes one user module that imports nothing and names each constant.
package rtc_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses; bit 7 of an address selects a write
    localparam int         RW_SELECT_BIT  = 7;
    localparam logic [7:0] CTRL_RD_ADDR   = 8'h0F;
    localparam logic [7:0] CTRL_WR_ADDR   = 8'h8F;
    localparam logic [7:0] STAT_RD_ADDR   = 8'h10;
    localparam logic [7:0] CHG_RD_ADDR    = 8'h11;
    localparam logic [7:0] CHG_WR_ADDR    = 8'h91;

    // Alarm register ranges, low seven address bits (read and write alike)
    localparam logic [6:0] ALM0_FIRST     = 7'h07;
    localparam logic [6:0] ALM0_LAST      = 7'h0A;
    localparam logic [6:0] ALM1_FIRST     = 7'h0B;
    localparam logic [6:0] ALM1_LAST      = 7'h0E;

    // Burst pointer wrap points
    localparam logic [7:0] RTC_RD_FIRST   = 8'h00;
    localparam logic [7:0] RTC_RD_LAST    = 8'h1F;
    localparam logic [7:0] RAM_RD_FIRST   = 8'h20;
    localparam logic [7:0] RAM_RD_LAST    = 8'h7F;
    localparam logic [7:0] RTC_WR_FIRST   = 8'h80;
    localparam logic [7:0] RTC_WR_LAST    = 8'h9F;
    localparam logic [7:0] RAM_WR_FIRST   = 8'hA0;
    localparam logic [7:0] RAM_WR_LAST    = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int         OSC_STOP_BIT   = 7;
    localparam int         WRITE_LOCK_BIT = 6;
    localparam int         ROUTE_SEL_BIT  = 2;
    localparam int         ALM1_EN_BIT    = 1;
    localparam int         ALM0_EN_BIT    = 0;
    localparam logic [7:0] CTRL_WR_MASK   = 8'hC7;
    localparam logic [7:0] CTRL_RESET     = 8'h80;

    // Charge configuration fields
    localparam int         KEY_MSB        = 7;
    localparam int         KEY_LSB        = 4;
    localparam int         DIODE_MSB      = 3;
    localparam int         DIODE_LSB      = 2;
    localparam int         RES_MSB        = 1;
    localparam int         RES_LSB        = 0;
    localparam logic [3:0] CHARGE_KEY_ON  = 4'hA;
    localparam logic [1:0] DIODE_ONE      = 2'h1;
    localparam logic [1:0] DIODE_TWO      = 2'h2;
    localparam logic [1:0] RES_OFF        = 2'h0;
    localparam logic [7:0] CHG_RESET      = 8'h5C;

    // Serial framing
    localparam logic [2:0] BIT_CNT_LAST   = 3'h7;

endpackage

// ### rtc_control_status_regs.sv
// Control, status and charge configuration registers of a serial clock,
// with the serial slave that reaches them over ce, link_sclk, sdi and sdo.
// Assumes alarm match pulses and supply comparator levels from outside;
// serial transfers latch sdi on the rising edge of link_sclk (mode 3).
//
// Overview of operation
// - Control register at 0Fh read, 8Fh write
// - Oscillator runs while stop bit is zero
// - Stop bit forced to one at power-up
// - Write lock blocks register writes except to the lock bit
// - Route one: separate alarm interrupt outputs
// - Route zero: either alarm on output 0
// - Alarm 0 flag gated by its enable
// - Alarm 1 flag gated, routed by select
// - Read-only status at 10h with flags
// - Alarm 0 match sets its flag
// - Pointer at alarm 0 clears flag
// - Alarm 1 match sets, pointer clears
// - Charge register at 11h read, 91h write
// - Charging needs key pattern 1010
// - Diode field 01 or 10, else off
// - Resistor field nonzero, zero disables charging
// - Charge register resets to 5Ch
// - Low primary supply blocks writes on battery
// - Rechargeable backup: no supply write block
// - Alarm address ranges 87h-8Ah, 8Bh-8Eh
// - Flags set on each clock update match
// - Address bit 7 selects write or read
`timescale 1ns/1ps

module rtc_control_status_regs (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       link_sclk,
    input  wire logic       ce,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe,
    input  wire logic       alarm0_match,
    input  wire logic       alarm1_match,
    input  wire logic       primary_below_battery,
    input  wire logic       secondary_rechargeable,
    output logic            osc_run,
    output logic            charge_enable,
    output logic            charge_two_diodes,
    output logic [1:0]      charge_res_sel,
    output logic            irq_out0_n,
    output logic            irq_out1_n
);

    ////////////////////////////////////////////////////////////////////////
    // State types
    // Two clocks, so the state splits into two link structs and one system struct

    // Frame state, cleared whenever ce is low
    typedef struct packed {
        logic       have_addr;
        logic [2:0] bit_cnt;
        logic [6:0] shift_in;
        logic [7:0] ptr;
        logic [7:0] out_sh;
        logic       reading;
    } link_frame_t;

    // Event carriers toward the system clock, kept across frames
    typedef struct packed {
        logic       wr_tog;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic       acc_tog;
        logic [7:0] acc_addr;
    } link_hold_t;

    // System clock state
    typedef struct packed {
        logic        ce_meta;
        logic        ce_sync;
        logic [2:0]  wr_sync;
        logic [2:0]  acc_sync;
        logic        low_meta;
        logic        low_sync;
        logic        rech_meta;
        logic        rech_sync;
        logic [7:0]  ctrl;
        logic [7:0]  charge;
        logic        flag0;
        logic        flag1;
        logic [23:0] snap;
        logic        irq0_n;
        logic        irq1_n;
        logic        osc_run;
        logic        charge_en;
        logic        two_diodes;
        logic [1:0]  res_sel;
    } sys_state_t;

    link_frame_t frame;
    link_frame_t next_frame;
    link_hold_t  hold;
    link_hold_t  next_hold;
    sys_state_t  sys;
    sys_state_t  next_sys;

    logic        wr_fire;
    logic        acc_fire;
    logic [7:0]  acc_val;
    logic [7:0]  rx_byte;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Burst pointer step with wrap inside the selected space
    // Wraps keep a burst inside clock space or inside user memory
    function automatic logic [7:0] step_ptr(input logic [7:0] p);
        logic [7:0] n;
        n = 8'(p + 8'h01);
        unique case (p)
            rtc_regs_pkg::RTC_RD_LAST: n = rtc_regs_pkg::RTC_RD_FIRST;
            rtc_regs_pkg::RAM_RD_LAST: n = rtc_regs_pkg::RAM_RD_FIRST;
            rtc_regs_pkg::RTC_WR_LAST: n = rtc_regs_pkg::RTC_WR_FIRST;
            rtc_regs_pkg::RAM_WR_LAST: n = rtc_regs_pkg::RAM_WR_FIRST;
            default:                   n = 8'(p + 8'h01);
        endcase
        return n;
    endfunction

    // Read data for a pointer value from the frozen snapshot
    // Unmapped addresses read as zero from this block
    function automatic logic [7:0] read_byte(input logic [7:0]  p,
                                             input logic [23:0] s);
        logic [7:0] d;
        d = 8'h00;
        if (p == rtc_regs_pkg::CTRL_RD_ADDR) begin
            d = s[23:16];
        end else if (p == rtc_regs_pkg::STAT_RD_ADDR) begin
            d = s[15:8];
        end else if (p == rtc_regs_pkg::CHG_RD_ADDR) begin
            d = s[7:0];
        end
        return d;
    endfunction

    // Pointer inside an alarm register range, either direction
    // Bit 7 is ignored, so read and write addresses both count
    function automatic logic in_range(input logic [7:0] p,
                                      input logic [6:0] lo,
                                      input logic [6:0] hi);
        return (p[6:0] >= lo) && (p[6:0] <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain: address byte then data bytes, MSB first
    // Frame flops run only on link_sclk and clear with ce low, so a
    // byte cut short by ce never reaches the register file.
    // Reads use the snapshot, which stands still from two system
    // cycles after ce rises; the first byte is read far later.

    // Shift, decode address, step pointer, raise events
    always_comb begin
        next_frame = frame;
        wr_fire    = 1'b0;
        acc_fire   = 1'b0;
        acc_val    = frame.ptr;
        rx_byte    = {frame.shift_in, sdi};
        next_frame.bit_cnt  = 3'(frame.bit_cnt + 3'h1);
        next_frame.shift_in = rx_byte[6:0];
        next_frame.out_sh   = {frame.out_sh[6:0], 1'b0};
        // Eighth edge of a byte: address load or burst step
        if (frame.bit_cnt == rtc_regs_pkg::BIT_CNT_LAST) begin
            if (!frame.have_addr) begin
                next_frame.have_addr = 1'b1;
                next_frame.ptr       = rx_byte;
                // Address bit 7 low means a read transfer
                next_frame.reading   =
                    ~rx_byte[rtc_regs_pkg::RW_SELECT_BIT];
                next_frame.out_sh    = read_byte(rx_byte, sys.snap);
                acc_fire = 1'b1;
                acc_val  = rx_byte;
            end else begin
                wr_fire = ~frame.reading;
                next_frame.ptr    = step_ptr(frame.ptr);
                next_frame.out_sh = read_byte(step_ptr(frame.ptr),
                                              sys.snap);
                acc_fire = 1'b1;
                acc_val  = step_ptr(frame.ptr);
            end
        end
    end

    // Frame registers, cleared while ce is low
    // ce acts as an asynchronous clear of the whole frame
    always_ff @(posedge link_sclk or negedge ce) begin
        if (!ce) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // Hold written byte and pointer while the toggles cross over
    // They stay put until the next byte completes, eight link edges
    // later, far beyond the three-cycle crossing
    always_comb begin
        next_hold = hold;
        if (wr_fire) begin
            next_hold.wr_tog  = ~hold.wr_tog;
            next_hold.wr_addr = frame.ptr;
            next_hold.wr_data = rx_byte;
        end
        if (acc_fire) begin
            next_hold.acc_tog  = ~hold.acc_tog;
            next_hold.acc_addr = acc_val;
        end
    end

    // Event carriers survive the end of a frame
    // Cleared by rst at any time, whether ce is high or low
    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            hold <= '0;
        end else begin
            hold <= next_hold;
        end
    end

    // Serial output; only driven during the data phase of a read
    // sdo_oe stays high through every burst byte until ce falls
    assign sdo    = frame.out_sh[7];
    assign sdo_oe = frame.reading;

    ////////////////////////////////////////////////////////////////////////
    // System domain: register file, flags, interrupts, charger
    // Link events arrive as toggles; a change between the second and
    // third synchroniser stages is one event, one cycle long.
    // Supply levels pass two flops before anything reads them.

    always_comb begin
        logic       wr_evt;
        logic       acc_evt;
        logic       supply_block;
        logic       clr0;
        logic       clr1;
        logic       act0;
        logic       act1;
        logic [1:0] diode;
        logic [1:0] res;
        next_sys = sys;
        wr_evt       = 1'b0;
        acc_evt      = 1'b0;
        supply_block = 1'b0;
        clr0         = 1'b0;
        clr1         = 1'b0;
        act0         = 1'b0;
        act1         = 1'b0;
        diode        = 2'h0;
        res          = 2'h0;

        // Synchronisers for ce, event toggles and supply levels
        next_sys.ce_meta   = ce;
        next_sys.ce_sync   = sys.ce_meta;
        next_sys.wr_sync   = {sys.wr_sync[1:0], hold.wr_tog};
        next_sys.acc_sync  = {sys.acc_sync[1:0], hold.acc_tog};
        next_sys.low_meta  = primary_below_battery;
        next_sys.low_sync  = sys.low_meta;
        next_sys.rech_meta = secondary_rechargeable;
        next_sys.rech_sync = sys.rech_meta;
        wr_evt  = sys.wr_sync[2] ^ sys.wr_sync[1];
        acc_evt = sys.acc_sync[2] ^ sys.acc_sync[1];

        // Supply protection only with a primary cell backup
        supply_block = sys.low_sync & ~sys.rech_sync;

        // Refused writes leave no trace at the ports; the host reads back
        // A locked file still takes the lock bit, or it could never
        // be unlocked again
        // Register writes
        if (wr_evt && !supply_block) begin
            if (hold.wr_addr == rtc_regs_pkg::CTRL_WR_ADDR) begin
                if (sys.ctrl[rtc_regs_pkg::WRITE_LOCK_BIT]) begin
                    // Only the lock bit itself may change
                    next_sys.ctrl[rtc_regs_pkg::WRITE_LOCK_BIT] =
                        hold.wr_data[rtc_regs_pkg::WRITE_LOCK_BIT];
                end else begin
                    next_sys.ctrl = hold.wr_data &
                                    rtc_regs_pkg::CTRL_WR_MASK;
                end
            end else if (hold.wr_addr == rtc_regs_pkg::CHG_WR_ADDR &&
                         !sys.ctrl[rtc_regs_pkg::WRITE_LOCK_BIT]) begin
                next_sys.charge = hold.wr_data;
            end
        end

        // Pointer reaching an alarm register clears its flag
        // Address load and every burst step both count as an access
        if (acc_evt) begin
            clr0 = in_range(hold.acc_addr, rtc_regs_pkg::ALM0_FIRST,
                            rtc_regs_pkg::ALM0_LAST);
            clr1 = in_range(hold.acc_addr, rtc_regs_pkg::ALM1_FIRST,
                            rtc_regs_pkg::ALM1_LAST);
        end

        // A match in the clearing cycle wins
        // Clearing it there would lose an alarm for good
        next_sys.flag0 = (sys.flag0 & ~clr0) | alarm0_match;
        next_sys.flag1 = (sys.flag1 & ~clr1) | alarm1_match;

        // Interrupt routing, low while flag and enable hold
        // Built from next flag and control values, so the outputs move
        // in the same cycle as the flags and never lag them
        act0 = next_sys.flag0 &
               next_sys.ctrl[rtc_regs_pkg::ALM0_EN_BIT];
        act1 = next_sys.flag1 &
               next_sys.ctrl[rtc_regs_pkg::ALM1_EN_BIT];
        if (next_sys.ctrl[rtc_regs_pkg::ROUTE_SEL_BIT]) begin
            next_sys.irq0_n = ~act0;
            next_sys.irq1_n = ~act1;
        end else begin
            next_sys.irq0_n = ~(act0 | act1);
            next_sys.irq1_n = 1'b1;
        end

        // Oscillator runs while the stop bit is clear
        // No oscillator here; the stop bit only drives osc_run
        next_sys.osc_run =
            ~next_sys.ctrl[rtc_regs_pkg::OSC_STOP_BIT];

        // Charger decode from key, diode and resistor fields
        // Any field outside the allowed patterns keeps the charger off
        diode = next_sys.charge[rtc_regs_pkg::DIODE_MSB:
                                rtc_regs_pkg::DIODE_LSB];
        res   = next_sys.charge[rtc_regs_pkg::RES_MSB:
                                rtc_regs_pkg::RES_LSB];
        next_sys.charge_en =
            (next_sys.charge[rtc_regs_pkg::KEY_MSB:rtc_regs_pkg::KEY_LSB]
                == rtc_regs_pkg::CHARGE_KEY_ON) &&
            (diode == rtc_regs_pkg::DIODE_ONE ||
             diode == rtc_regs_pkg::DIODE_TWO) &&
            (res != rtc_regs_pkg::RES_OFF);
        next_sys.two_diodes = (diode == rtc_regs_pkg::DIODE_TWO);
        next_sys.res_sel    = res;

        // Read snapshot frozen while a frame is in progress
        // Keeps a burst read coherent while matches or writes land
        // in the middle of it
        if (!sys.ce_sync) begin
            next_sys.snap = {next_sys.ctrl,
                             6'h00, next_sys.flag1, next_sys.flag0,
                             next_sys.charge};
        end

        // Synchronous reset values
        // Lock and routing start cleared; the host must still clear
        // the lock first, as it cannot rely on that
        if (rst) begin
            next_sys        = '0;
            next_sys.ctrl   = rtc_regs_pkg::CTRL_RESET;
            next_sys.charge = rtc_regs_pkg::CHG_RESET;
            next_sys.snap   = {rtc_regs_pkg::CTRL_RESET, 8'h00,
                               rtc_regs_pkg::CHG_RESET};
            next_sys.irq0_n = 1'b1;
            next_sys.irq1_n = 1'b1;
        end
    end

    // System state register
    always_ff @(posedge sys_clk) begin
        sys <= next_sys;
    end

    // Outputs straight from system flops
    assign osc_run           = sys.osc_run;
    assign charge_enable     = sys.charge_en;
    assign charge_two_diodes = sys.two_diodes;
    assign charge_res_sel    = sys.res_sel;
    assign irq_out0_n        = sys.irq0_n;
    assign irq_out1_n        = sys.irq1_n;

endmodule

// ### rtc_regs_properties.sv
// Checker for the clock's special-purpose register block, on its ports.
// Assumes bind to rtc_control_status_regs; link clock idles between frames.
`timescale 1ns/1ps

module rtc_regs_properties (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       link_sclk,
    input wire logic       ce,
    input wire logic       sdi,
    input wire logic       sdo_oe,
    input wire logic       alarm0_match,
    input wire logic       alarm1_match,
    input wire logic       primary_below_battery,
    input wire logic       secondary_rechargeable,
    input wire logic       osc_run,
    input wire logic       charge_enable,
    input wire logic [1:0] charge_res_sel,
    input wire logic       irq_out0_n,
    input wire logic       irq_out1_n
);
    logic [3:0] edge_cnt;
    logic       frame_wr;
    logic [3:0] idle_cnt;

    // Link edges in a frame and its write bit
    always_ff @(posedge link_sclk or negedge ce) begin
        if (!ce) begin
            edge_cnt <= 4'h0;
            frame_wr <= 1'b0;
        end else begin
            if (edge_cnt == 4'h0) begin
                frame_wr <= sdi;
            end
            if (edge_cnt != 4'h9) begin
                edge_cnt <= edge_cnt + 4'h1;
            end
        end
    end

    // Cycles since the last serial frame
    always_ff @(posedge sys_clk) begin
        if (ce || rst) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end

    ////////////////////////////////////////
    AST_RESET_OSC: assert property (@(posedge sys_clk)
        rst |=> !osc_run && irq_out0_n && irq_out1_n)
        else $error("reset left oscillator or interrupt active");
    AST_RESET_CHARGE: assert property (@(posedge sys_clk)
        rst |=> !charge_enable && charge_res_sel == 2'h0)
        else $error("reset left charger set");
    AST_CHARGE_RES: assert property (@(posedge sys_clk)
        disable iff (rst) charge_enable |-> charge_res_sel != 2'h0)
        else $error("charger on with no resistor");
    AST_SUPPLY_BLOCK: assert property (@(posedge sys_clk)
        disable iff (rst)
        (primary_below_battery && !secondary_rechargeable) [*6]
        |=> $stable(osc_run) && $stable(charge_enable)
        && $stable(charge_res_sel))
        else $error("write landed on low primary supply");
    AST_SDO_RELEASE: assert property (@(posedge sys_clk)
        disable iff (rst) !ce |-> !sdo_oe)
        else $error("sdo driven while deselected");
    AST_WRITE_QUIET: assert property (@(posedge link_sclk)
        disable iff (rst || !ce) edge_cnt >= 4'h8 && frame_wr |-> !sdo_oe)
        else $error("sdo driven in a write frame");
    AST_READ_DRIVE: assert property (@(posedge link_sclk)
        disable iff (rst || !ce) edge_cnt >= 4'h8 && !frame_wr |-> sdo_oe)
        else $error("sdo idle in a read frame");
    AST_IRQ0_CAUSE: assert property (@(posedge sys_clk)
        disable iff (rst) $fell(irq_out0_n)
        |-> $past(alarm0_match) || $past(alarm1_match) || idle_cnt < 4'h8)
        else $error("interrupt 0 fell without cause");
    AST_IRQ1_CAUSE: assert property (@(posedge sys_clk)
        disable iff (rst) $fell(irq_out1_n)
        |-> $past(alarm1_match) || idle_cnt < 4'h8)
        else $error("interrupt 1 fell without cause");
    AST_IRQ_RELEASE: assert property (@(posedge sys_clk)
        disable iff (rst) $rose(irq_out0_n) || $rose(irq_out1_n)
        |-> idle_cnt < 4'h8)
        else $error("interrupt released without access");
endmodule

bind rtc_control_status_regs rtc_regs_properties i_rtc_regs_properties (
    .sys_clk(sys_clk), .rst(rst), .link_sclk(link_sclk), .ce(ce),
    .sdi(sdi), .sdo_oe(sdo_oe), .alarm0_match(alarm0_match),
    .alarm1_match(alarm1_match),
    .primary_below_battery(primary_below_battery),
    .secondary_rechargeable(secondary_rechargeable), .osc_run(osc_run),
    .charge_enable(charge_enable), .charge_res_sel(charge_res_sel),
    .irq_out0_n(irq_out0_n), .irq_out1_n(irq_out1_n));

// ### rtc_host_model.sv
// Host serial master: mode 3 frames, MSB first, 64 ns link clock.
// Assumes the caller leaves a frame's gap before calling again.
`timescale 1ns/1ps

module rtc_host_model (
    output logic       link_sclk,
    output logic       ce,
    output logic       sdi,
    input  wire logic  sdo,
    output logic [7:0] rd_data,
    output logic       rd_tog
);
    // Idle bus: clock high and still, deselected
    initial begin
        link_sclk = 1'b1;
        ce = 1'b0;
        sdi = 1'b0;
        rd_data = 8'h00;
        rd_tog = 1'b0;
    end

    // One byte; sdi set at the fall, sdo taken before the rise
    task automatic shift(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            link_sclk = 1'b0;
            sdi = b[i];
            #32;
            r[i] = sdo;
            link_sclk = 1'b1;
            #32;
        end
    endtask

    // Address byte then n data bytes; each read byte is handed on
    task automatic frame(input logic [7:0] a, input logic [7:0] d,
                         input int n);
        logic [7:0] r;
        #7.3 ce = 1'b1;
        #32;
        shift(a, r);
        repeat (n) begin
            shift(d, r);
            if (!a[7]) begin
                rd_data = r;
                rd_tog = ~rd_tog;
            end
        end
        #32 ce = 1'b0;
        sdi = ~sdi;
        #64;
    endtask
endmodule

// ### rtc_control_status_regs_test.sv
// Testbench: serial frames, alarm pulses and supply levels into the block.
// Assumes the design, its bound checker and the host model are compiled.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module rtc_control_status_regs_test;
    logic       sys_clk, rst, link_sclk, ce, sdi, sdo, sdo_oe;
    logic       alarm0_match, alarm1_match;
    logic       primary_below_battery, secondary_rechargeable;
    logic       osc_run, charge_enable, charge_two_diodes;
    logic       irq_out0_n, irq_out1_n, rd_tog, en;
    logic [1:0] charge_res_sel;
    logic [7:0] rd_data, v, e_rd;
    logic [3:0] ex;
    logic [7:0] exp_q[$];
    int         n_errors = 0;
    int         n_compared = 0;
    int         cycles = 0;

    rtc_control_status_regs i_rtc_control_status_regs (
        .sys_clk(sys_clk), .rst(rst), .link_sclk(link_sclk), .ce(ce),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .alarm0_match(alarm0_match), .alarm1_match(alarm1_match),
        .primary_below_battery(primary_below_battery),
        .secondary_rechargeable(secondary_rechargeable),
        .osc_run(osc_run), .charge_enable(charge_enable),
        .charge_two_diodes(charge_two_diodes),
        .charge_res_sel(charge_res_sel),
        .irq_out0_n(irq_out0_n), .irq_out1_n(irq_out1_n));
    rtc_host_model i_rtc_host_model (.link_sclk(link_sclk), .ce(ce),
        .sdi(sdi), .sdo(sdo), .rd_data(rd_data), .rd_tog(rd_tog));

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_rtc_host_model.frame(a, d, 1);
        tick(2);
    endtask

    // Note the expected byte, then read it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wr(a, 8'h00);
    endtask

    // One-cycle match pulse: bit 0 alarm 0, bit 1 alarm 1
    task automatic pulse(input logic [1:0] s);
        alarm0_match = s[0];
        alarm1_match = s[1];
        tick(1);
        alarm0_match = 1'b0;
        alarm1_match = 1'b0;
        tick(2);
    endtask

    task automatic close_out();
        if (exp_q.size() != 0) begin
            n_errors++;
        end
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Oldest note against each byte the host took in
    always @(rd_tog) begin
        if (exp_q.size() > 0) begin
            e_rd = exp_q.pop_front();
            `CHK(rd_data, e_rd)
        end
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'h469AF0B9));
        rst = 1'b1;
        alarm0_match = 1'b0;
        alarm1_match = 1'b0;
        primary_below_battery = 1'b0;
        secondary_rechargeable = 1'b0;
        tick(20);
        rst = 1'b0;
        tick(3);
        // Reset contents by one burst read from control
        exp_q.push_back(8'h80);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h5C);
        i_rtc_host_model.frame(8'h0F, 8'h00, 3);
        tick(2);
        `CHK({osc_run, charge_enable, irq_out0_n, irq_out1_n}, 4'h3)
        // Clear lock first; lock, unlock, then separate outputs
        wr(8'h8F, 8'h00);
        wr(8'h8F, 8'hFF);
        rd(8'h0F, 8'hC7);
        wr(8'h8F, 8'h07);
        rd(8'h0F, 8'h87);
        wr(8'h8F, 8'h07);
        rd(8'h0F, 8'h07);
        `CHK(osc_run, 1'b1)
        pulse(2'h1);
        `CHK({irq_out0_n, irq_out1_n}, 2'h1)
        pulse(2'h2);
        `CHK({irq_out0_n, irq_out1_n}, 2'h0)
        rd(8'h10, 8'h03);
        wr(8'h8B, 8'h00);
        `CHK({irq_out0_n, irq_out1_n}, 2'h1)
        rd(8'h10, 8'h01);
        wr(8'h8A, 8'h00);
        `CHK({irq_out0_n, irq_out1_n}, 2'h3)
        // Shared output, alarm 1 enabled only
        wr(8'h8F, 8'h02);
        pulse(2'h2);
        `CHK({irq_out0_n, irq_out1_n}, 2'h1)
        pulse(2'h1);
        wr(8'h8E, 8'h00);
        `CHK({irq_out0_n, irq_out1_n}, 2'h3)
        rd(8'h10, 8'h01);
        wr(8'h87, 8'h00);
        rd(8'h10, 8'h00);
        // Charge settings: random fields, key forced on odd passes
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            if (i[0]) begin
                v[7:4] = 4'hA;
            end
            if (i == 1) begin
                v[3:0] = 4'h5;
            end
            en = v[7:4] == 4'hA && v[3:2] inside {2'h1, 2'h2}
                 && v[1:0] != 2'h0;
            ex = {en, v[3:2] == 2'h2, v[1:0]};
            wr(8'h91, v);
            `CHK({charge_enable, charge_two_diodes, charge_res_sel}, ex)
            rd(8'h11, v);
        end
        // Lock: only the lock bit stays writable
        wr(8'h8F, 8'h47);
        wr(8'h91, 8'h00);
        rd(8'h11, v);
        wr(8'h8F, 8'h80);
        rd(8'h0F, 8'h07);
        // Low primary supply on a plain battery, then on a rechargeable one
        primary_below_battery = 1'b1;
        tick(4);
        wr(8'h8F, 8'h80);
        rd(8'h0F, 8'h07);
        secondary_rechargeable = 1'b1;
        tick(4);
        wr(8'h8F, 8'h80);
        rd(8'h0F, 8'h80);
        `CHK(osc_run, 1'b0)
        close_out();
    end
endmodule
